// File: alu_skip_regs.svh
`ifndef ALU_SKIP_REGS_SVH
`define ALU_SKIP_REGS_SVH
// How it works
// - Met skip discards next, two cycles total.
// - Skip when selected memory bit is one.
// - Accumulator gets acc plus inverted byte plus one.
// - Memory gets acc minus byte, flags updated.
// - Accumulator gets acc minus immediate, flags updated.
// - Swap memory byte nibbles, flags untouched.
// - Accumulator gets nibble-swapped byte, memory untouched.
// - Skip when memory byte is zero.
// - Copy byte to accumulator, skip if zero.
// - Skip when selected memory bit is zero.
// - Table read within current page, high to latch.
// - Table read within last page, high to latch.
// - Accumulator gets acc xor byte, zero flag only.
// - Memory gets acc xor byte, zero flag only.
// - Accumulator gets acc xor immediate, zero only.
// - Accumulator gets byte plus one, skip on wrap.

// ==========================================================
// Register byte offsets.
`define A_CMD 8'h00
`define A_IMM 8'h04
`define A_ACC 8'h08
`define A_STATUS 8'h0c
`define A_TABLE_PTR 8'h10
`define A_TABLE_HIGH 8'h14
`define A_PAGE 8'h18
`define A_MADDR 8'h1c
`define A_MDATA 8'h20

// ==========================================================
// Field positions and fixed values.
`define CMD_OP_LSB 0
`define CMD_BIT_LSB 8
`define CMD_ADR_LSB 16
`define ST_C 0
`define ST_HALF_CARRY 1
`define ST_Z 2
`define ST_OVERFLOW 3
`define ST_BUSY 4
`define ST_SKIP 5
`define RST_BYTE 8'h00
`define HSIZE_WORD 3'h2
`define HRESP_OKAY 1'b0
`endif

// File: alu_skip_pkg.sv
package alu_skip_pkg;
  typedef enum logic [3:0] {
    op_skip_if_bit_set = 4'h0,
    op_skip_if_bit_clr = 4'h1,
    op_skip_if_zero = 4'h2,
    op_copy_and_test_zero = 4'h3,
    op_increment_test_to_acc = 4'h4,
    op_subtract_to_acc = 4'h5,
    op_subtract_to_memory = 4'h6,
    op_subtract_immediate = 4'h7,
    op_nibble_exchange = 4'h8,
    op_nibble_exchange_to_acc = 4'h9,
    op_table_read_current_page = 4'ha,
    op_table_read_last_page = 4'hb,
    op_exclusive_or_to_acc = 4'hc,
    op_exclusive_or_to_memory = 4'hd,
    op_exclusive_or_immediate = 4'he
  } op_e;

  typedef enum logic [3:0] {
    st_idle = 4'b0001,
    st_table = 4'b0010,
    st_exec = 4'b0100,
    st_dummy = 4'b1000
  } state_e;

  typedef struct packed {
    logic [7:0] addr;
    logic [2:0] bsel;
    op_e op;
  } cmd_s;

  typedef struct packed {
    logic overflow_flag;
    logic z;
    logic half_carry_flag;
    logic c;
  } flags_s;

  typedef struct packed {
    logic valid;
    logic write;
    logic [7:0] addr;
  } ahb_req_s;
endpackage

// File: alu_skip_core.sv
`timescale 1ns/1ps
`include "alu_skip_regs.svh"

module alu_skip_core #(
  parameter int DEPTH = 192,
  parameter int PAGE_W = 4,
  parameter int PROG_W = 16
) (
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic resetn,
  // AHB-Lite slave.
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  // Program memory read port.
  output logic [PAGE_W+7:0] prog_addr,
  input wire logic [PROG_W-1:0] prog_rdata,
  // Core sequencing.
  output logic instr_done,
  output logic discard
);

  // ========================================================
  // Architectural state.
  alu_skip_pkg::state_e state;
  alu_skip_pkg::state_e next_state;
  alu_skip_pkg::cmd_s cmd;
  alu_skip_pkg::flags_s flags;
  alu_skip_pkg::flags_s next_flags;
  alu_skip_pkg::ahb_req_s req;
  logic [7:0] acc;
  logic [7:0] imm;
  logic [7:0] table_pointer;
  logic [PROG_W-9:0] table_high_latch;
  logic [PAGE_W-1:0] page;
  logic [7:0] maddr;
  logic [7:0] mem [DEPTH];
  logic [PROG_W-1:0] prog_word;
  logic skipped;

  logic [7:0] m;
  logic [7:0] opnd;
  logic [8:0] sub_sum;
  logic [4:0] sub_low;
  logic [7:0] sub_res;
  logic [7:0] next_acc;
  logic next_mem_we;
  logic [7:0] next_mem_data;
  logic skip;
  logic bus_wr;
  logic cmd_wr;

  function automatic logic [7:0] mem_read(input logic [7:0] a,
                                          input logic [7:0] arr [DEPTH]);
    mem_read = (int'(a) < DEPTH) ? arr[a] : `RST_BYTE;
  endfunction

  function automatic logic is_table(input logic [3:0] op);
    is_table = op == alu_skip_pkg::op_table_read_current_page ||
               op == alu_skip_pkg::op_table_read_last_page;
  endfunction

  // ========================================================
  // AHB-Lite slave. Zero wait states, always OKAY.
  assign hreadyout = 1'b1;
  assign hresp = `HRESP_OKAY;
  assign bus_wr = req.valid && req.write;
  // Commands arriving while busy are dropped; software polls busy.
  assign cmd_wr = bus_wr && req.addr == `A_CMD &&
                  state == alu_skip_pkg::st_idle;

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      req <= '0;
    end else if (hready) begin
      req.valid <= hsel && htrans[1] && hsize == `HSIZE_WORD;
      req.write <= hwrite;
      req.addr <= haddr[7:0];
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      hrdata <= '0;
    end else if (hready && hsel && htrans[1] && !hwrite) begin
      unique case (haddr[7:0])
        `A_CMD: hrdata <= {8'h00, cmd.addr, 5'h00, cmd.bsel, 4'h0, cmd.op};
        `A_IMM: hrdata <= {24'h0, imm};
        `A_ACC: hrdata <= {24'h0, acc};
        `A_STATUS: hrdata <= {26'h0, skipped,
                              state != alu_skip_pkg::st_idle, flags};
        `A_TABLE_PTR: hrdata <= {24'h0, table_pointer};
        `A_TABLE_HIGH: hrdata <= 32'(table_high_latch);
        `A_PAGE: hrdata <= 32'(page);
        `A_MADDR: hrdata <= {24'h0, maddr};
        `A_MDATA: hrdata <= {24'h0, mem_read(maddr, mem)};
        default: hrdata <= '0;
      endcase
    end
  end

  // ========================================================
  // Software-written configuration.
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      cmd <= '0;
      imm <= `RST_BYTE;
      table_pointer <= `RST_BYTE;
      page <= '0;
      maddr <= `RST_BYTE;
    end else if (bus_wr) begin
      if (cmd_wr) begin
        cmd.op <= alu_skip_pkg::op_e'(hwdata[`CMD_OP_LSB +: 4]);
        cmd.bsel <= hwdata[`CMD_BIT_LSB +: 3];
        cmd.addr <= hwdata[`CMD_ADR_LSB +: 8];
      end
      if (req.addr == `A_IMM) imm <= hwdata[7:0];
      if (req.addr == `A_TABLE_PTR) table_pointer <= hwdata[7:0];
      if (req.addr == `A_PAGE) page <= hwdata[PAGE_W-1:0];
      if (req.addr == `A_MADDR) maddr <= hwdata[7:0];
    end
  end

  // ========================================================
  // Sequencer. A taken skip adds one dummy cycle.
  always_comb begin
    next_state = state;
    unique case (state)
      alu_skip_pkg::st_idle: begin
        if (cmd_wr) begin
          if (is_table(hwdata[`CMD_OP_LSB +: 4])) begin
            next_state = alu_skip_pkg::st_table;
          end else begin
            next_state = alu_skip_pkg::st_exec;
          end
        end
      end
      alu_skip_pkg::st_table: next_state = alu_skip_pkg::st_exec;
      alu_skip_pkg::st_exec: next_state = skip ? alu_skip_pkg::st_dummy :
          alu_skip_pkg::st_idle;
      alu_skip_pkg::st_dummy: next_state = alu_skip_pkg::st_idle;
    endcase
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      state <= alu_skip_pkg::st_idle;
    end else begin
      state <= next_state;
    end
  end

  assign discard = state == alu_skip_pkg::st_dummy;
  assign instr_done = (state == alu_skip_pkg::st_exec && !skip) || discard;

  // ========================================================
  // Table read: page is current or the last one.
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      prog_addr <= '0;
    end else if (cmd_wr) begin
      prog_addr[7:0] <= table_pointer;
      if (hwdata[`CMD_OP_LSB +: 4] ==
          alu_skip_pkg::op_table_read_last_page) begin
        prog_addr[PAGE_W+7:8] <= '1;
      end else begin
        prog_addr[PAGE_W+7:8] <= page;
      end
    end
  end

  // The word is held one cycle so the memory output has a full period.
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      prog_word <= '0;
    end else if (state == alu_skip_pkg::st_table) begin
      prog_word <= prog_rdata;
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      table_high_latch <= '0;
    end else if (state == alu_skip_pkg::st_exec && is_table(cmd.op)) begin
      table_high_latch <= prog_word[PROG_W-1:8];
    end
  end

  // ========================================================
  // Datapath.
  assign m = mem_read(cmd.addr, mem);
  assign opnd = (cmd.op == alu_skip_pkg::op_subtract_immediate) ? imm : m;
  assign sub_sum = {1'b0, acc} + {1'b0, ~opnd} + 9'h001;
  assign sub_low = {1'b0, acc[3:0]} + {1'b0, ~opnd[3:0]} + 5'h01;
  assign sub_res = sub_sum[7:0];

  always_comb begin
    next_acc = acc;
    next_mem_we = 1'b0;
    next_mem_data = m;
    next_flags = flags;
    skip = 1'b0;
    unique case (cmd.op)
      alu_skip_pkg::op_skip_if_bit_set: skip = m[cmd.bsel];
      alu_skip_pkg::op_skip_if_bit_clr: skip = !m[cmd.bsel];
      alu_skip_pkg::op_skip_if_zero: skip = m == 8'h00;
      alu_skip_pkg::op_copy_and_test_zero: begin
        next_acc = m;
        skip = m == 8'h00;
      end
      alu_skip_pkg::op_increment_test_to_acc: begin
        next_acc = m + 8'h01;
        skip = m == 8'hff;
      end
      alu_skip_pkg::op_subtract_to_acc,
      alu_skip_pkg::op_subtract_immediate,
      alu_skip_pkg::op_subtract_to_memory: begin
        if (cmd.op == alu_skip_pkg::op_subtract_to_memory) begin
          next_mem_we = 1'b1;
          next_mem_data = sub_res;
        end else begin
          next_acc = sub_res;
        end
        next_flags.c = sub_sum[8];
        next_flags.half_carry_flag = sub_low[4];
        next_flags.z = sub_res == 8'h00;
        next_flags.overflow_flag = (acc[7] != opnd[7]) &&
                                   (sub_res[7] != acc[7]);
      end
      alu_skip_pkg::op_nibble_exchange: begin
        next_mem_we = 1'b1;
        next_mem_data = {m[3:0], m[7:4]};
      end
      alu_skip_pkg::op_nibble_exchange_to_acc: begin
        next_acc = {m[3:0], m[7:4]};
      end
      alu_skip_pkg::op_table_read_current_page,
      alu_skip_pkg::op_table_read_last_page: begin
        next_mem_we = 1'b1;
        next_mem_data = prog_word[7:0];
      end
      alu_skip_pkg::op_exclusive_or_to_acc: begin
        next_acc = acc ^ m;
        next_flags.z = (acc ^ m) == 8'h00;
      end
      alu_skip_pkg::op_exclusive_or_to_memory: begin
        next_mem_we = 1'b1;
        next_mem_data = acc ^ m;
        next_flags.z = (acc ^ m) == 8'h00;
      end
      alu_skip_pkg::op_exclusive_or_immediate: begin
        next_acc = acc ^ imm;
        next_flags.z = (acc ^ imm) == 8'h00;
      end
      default: skip = 1'b0;
    endcase
  end

  // ========================================================
  // Accumulator and flags. Execution wins over a bus write.
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      acc <= `RST_BYTE;
      flags <= '0;
      skipped <= 1'b0;
    end else if (state == alu_skip_pkg::st_exec) begin
      acc <= next_acc;
      flags <= next_flags;
      skipped <= skip;
    end else if (bus_wr && req.addr == `A_ACC) begin
      acc <= hwdata[7:0];
    end else if (bus_wr && req.addr == `A_STATUS) begin
      flags <= hwdata[3:0];
    end
  end

  // ========================================================
  // Data memory. Bus writes only while the core is idle; reads at any time.
  always_ff @(posedge ref_clk) begin
    if (state == alu_skip_pkg::st_exec && next_mem_we &&
        int'(cmd.addr) < DEPTH) begin
      mem[cmd.addr] <= next_mem_data;
    end else if (state == alu_skip_pkg::st_idle && bus_wr &&
                 req.addr == `A_MDATA && int'(maddr) < DEPTH) begin
      mem[maddr] <= hwdata[7:0];
    end
  end

  // ========================================================
  // Checks.
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);

  logic in_exec;
  assign in_exec = state == alu_skip_pkg::st_exec;

  a_skip_two_cycles: assert property (in_exec && skip |=>
    discard ##1 state == alu_skip_pkg::st_idle)
    else $error("skip did not take exactly one dummy cycle");
  a_noskip_one_cycle: assert property (in_exec && !skip |=>
    state == alu_skip_pkg::st_idle && !discard)
    else $error("non-skip took extra cycle");
  a_bit_set_skip: assert property (in_exec &&
    cmd.op == alu_skip_pkg::op_skip_if_bit_set |-> skip == m[cmd.bsel]
    ##1 $stable(flags))
    else $error("bit-set skip wrong");
  a_sub_acc_result: assert property (in_exec &&
    cmd.op == alu_skip_pkg::op_subtract_to_acc |=>
    acc == 8'($past(acc) - $past(m)) && flags.z == (acc == 8'h00))
    else $error("subtract to acc wrong");
  a_sub_mem_result: assert property (in_exec &&
    cmd.op == alu_skip_pkg::op_subtract_to_memory |=>
    $stable(acc) && m == 8'($past(acc) - $past(m)))
    else $error("subtract to memory wrong");
  a_sub_imm_carry: assert property (in_exec &&
    cmd.op == alu_skip_pkg::op_subtract_immediate |=>
    flags.c == ($past(acc) >= $past(imm)))
    else $error("immediate subtract carry wrong");
  a_swap_flags_kept: assert property (in_exec &&
    cmd.op == alu_skip_pkg::op_nibble_exchange |=>
    $stable(flags) && m == {$past(m[3:0]), $past(m[7:4])})
    else $error("nibble exchange wrong");
  a_swap_acc_mem: assert property (in_exec &&
    cmd.op == alu_skip_pkg::op_nibble_exchange_to_acc |=>
    $stable(m) && acc == {$past(m[3:0]), $past(m[7:4])})
    else $error("nibble exchange to acc wrong");
  a_zero_skip: assert property (in_exec &&
    cmd.op == alu_skip_pkg::op_skip_if_zero |-> skip == (m == 8'h00))
    else $error("zero skip wrong");
  a_copy_test_acc: assert property (in_exec &&
    cmd.op == alu_skip_pkg::op_copy_and_test_zero |=>
    acc == $past(m) && skipped == (acc == 8'h00))
    else $error("copy and test wrong");
  a_bit_clr_skip: assert property (in_exec &&
    cmd.op == alu_skip_pkg::op_skip_if_bit_clr |-> skip != m[cmd.bsel])
    else $error("bit-clear skip wrong");
  a_tbl_page_cur: assert property (state == alu_skip_pkg::st_table &&
    cmd.op == alu_skip_pkg::op_table_read_current_page |->
    prog_addr == {page, table_pointer})
    else $error("current page address wrong");
  a_tbl_page_last: assert property (state == alu_skip_pkg::st_table &&
    cmd.op == alu_skip_pkg::op_table_read_last_page |-> ##2
    &prog_addr[PAGE_W+7:8] &&
    table_high_latch == $past(prog_rdata[PROG_W-1:8], 2))
    else $error("last page table read wrong");
  a_xor_zero_only: assert property (in_exec &&
    cmd.op inside {alu_skip_pkg::op_exclusive_or_to_acc,
    alu_skip_pkg::op_exclusive_or_to_memory,
    alu_skip_pkg::op_exclusive_or_immediate} |=>
    $stable(flags.c) && $stable(flags.overflow_flag) &&
    $stable(flags.half_carry_flag))
    else $error("xor touched other flags");
  a_inc_test_wrap: assert property (in_exec &&
    cmd.op == alu_skip_pkg::op_increment_test_to_acc |=>
    acc == $past(m) + 8'h01 && $stable(m) && skipped == (acc == 8'h00))
    else $error("increment test wrong");

  c_skip_taken: cover property (in_exec && skip ##1 discard);
  c_table_read: cover property (state == alu_skip_pkg::st_table ##1 in_exec);
  c_sub_borrow: cover property (in_exec && cmd.op ==
    alu_skip_pkg::op_subtract_to_acc && !sub_sum[8]);
endmodule

// File: mcu_alu_skip_table_ops_tb_top.sv
`timescale 1ns/1ps
`include "alu_skip_regs.svh"

module mcu_alu_skip_table_ops_tb_top;
  // ==========================================================
  // Clock, reset and design hookup.
  logic ref_clk;
  logic resetn;
  logic hsel;
  logic [31:0] haddr;
  logic [1:0] htrans;
  logic hwrite;
  logic [2:0] hsize;
  logic [31:0] hwdata;
  wire logic hready;
  logic hreadyout;
  logic [31:0] hrdata;
  logic hresp;
  logic [11:0] prog_addr;
  logic [15:0] prog_rdata;
  logic instr_done;
  logic discard;
  int fails;
  int num_checks;
  logic [3:0] st;
  logic [31:0] last_cmd;

  // Page and pointer both shape the low byte, so a wrong page shows.
  function automatic logic [15:0] rom(input logic [11:0] a);
    return {a[7:0], a[11:4]};
  endfunction

  assign hready = hreadyout;
  assign prog_rdata = rom(prog_addr);

  alu_skip_core i_dut (
    .ref_clk(ref_clk), .resetn(resetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hreadyout(hreadyout), .hrdata(hrdata),
    .hresp(hresp), .prog_addr(prog_addr), .prog_rdata(prog_rdata),
    .instr_done(instr_done), .discard(discard)
  );

  initial ref_clk = 1'b0;
  always #2 ref_clk = ~ref_clk;

  // ==========================================================
  // Checking and bus tasks.
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    num_checks++;
    if (g !== e) begin
      fails++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic bus(input logic w, input logic [7:0] ad,
                     input logic [31:0] wd, output logic [31:0] rv);
    hsel <= 1'b1;
    haddr <= {24'h000000, ad};
    htrans <= 2'h2;
    hwrite <= w;
    hsize <= `HSIZE_WORD;
    do @(posedge ref_clk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge ref_clk); while (hready !== 1'b1);
    rv = hrdata;
    if (!w) chk({31'h0, hresp}, {31'h0, `HRESP_OKAY});
  endtask

  task automatic wr(input logic [7:0] ad, input logic [31:0] d);
    logic [31:0] t;
    bus(1'b1, ad, d, t);
  endtask

  task automatic rd(input logic [7:0] ad, input logic [31:0] m,
                    input logic [31:0] e);
    logic [31:0] t;
    bus(1'b0, ad, 32'h0, t);
    chk(t & m, e);
  endtask

  // ==========================================================
  // One instruction: load operands, start it, check every effect.
  task automatic exec(input logic [3:0] op, input logic [2:0] b,
                      input logic [7:0] ad, input logic [7:0] m,
                      input logic [7:0] a, input logic [7:0] x);
    logic [7:0] ea, em, r, o;
    logic [3:0] ef;
    logic sk, dsc, tbl;
    logic [8:0] s;
    logic [4:0] h;
    logic [11:0] pa;
    logic [15:0] w;
    int n;
    st = ~st;
    ea = a;
    em = m;
    ef = st;
    sk = 1'b0;
    tbl = (op == 4'ha || op == 4'hb);
    pa = {(op == 4'hb) ? 4'hf : 4'h6, x};
    w = rom(pa);
    o = (op == 4'h7 || op == 4'he) ? x : m;
    case (op)
      4'h0: sk = m[b];
      4'h1: sk = !m[b];
      4'h2: sk = (m == 8'h00);
      4'h3: begin
        ea = m;
        sk = (m == 8'h00);
      end
      4'h4: begin
        ea = m + 8'h01;
        sk = (ea == 8'h00);
      end
      4'h5, 4'h6, 4'h7: begin
        s = {1'b0, a} + {1'b0, ~o} + 9'h001;
        h = {1'b0, a[3:0]} + {1'b0, ~o[3:0]} + 5'h01;
        r = s[7:0];
        ef = {(a[7] != o[7]) && (r[7] != a[7]), r == 8'h00, h[4], s[8]};
        if (op == 4'h6) em = r;
        else ea = r;
      end
      4'h8: em = {m[3:0], m[7:4]};
      4'h9: ea = {m[3:0], m[7:4]};
      4'ha, 4'hb: em = w[7:0];
      4'hf: sk = 1'b0;
      default: begin
        r = a ^ o;
        ef[2] = (r == 8'h00);
        if (op == 4'hd) em = r;
        else ea = r;
      end
    endcase
    wr(`A_PAGE, 32'h6);
    wr(`A_TABLE_PTR, {24'h0, x});
    wr(`A_IMM, {24'h0, x});
    wr(`A_MADDR, {24'h0, ad});
    wr(`A_MDATA, {24'h0, m});
    wr(`A_ACC, {24'h0, a});
    wr(`A_STATUS, {28'h0, st});
    last_cmd = {8'h00, ad, 5'h00, b, 4'h0, op};
    wr(`A_CMD, last_cmd);
    n = 0;
    dsc = 1'b0;
    do begin
      @(posedge ref_clk);
      n++;
      dsc = dsc | (discard === 1'b1);
    end while (instr_done !== 1'b1 && n < 8);
    chk(n, (tbl ? 2 : 1) + sk);
    chk({31'h0, dsc}, {31'h0, sk});
    rd(`A_STATUS, 32'h3f, {26'h0, sk, 1'b0, ef});
    rd(`A_ACC, 32'hff, {24'h0, ea});
    rd(`A_MDATA, 32'hff, {24'h0, em});
    if (tbl) rd(`A_TABLE_HIGH, 32'hff, {24'h0, w[15:8]});
    $display("test op %h done", op);
  endtask

  // ==========================================================
  // Watchdog: the whole sequence needs about six hundred cycles.
  initial begin
    #80000;
    fails++;
    print_verdict;
  end

  initial begin
    fails = 0;
    num_checks = 0;
    st = 4'ha;
    last_cmd = 32'h0;
    resetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = `HSIZE_WORD;
    hwdata = 32'h0;
    repeat (4) @(posedge ref_clk);
    chk(hrdata, 32'h0);
    chk({30'h0, instr_done, discard}, 32'h0);
    resetn <= 1'b1;
    @(posedge ref_clk);
    rd(`A_ACC, 32'hff, 32'h0);
    rd(`A_STATUS, 32'h3f, 32'h0);
    $display("test reset done");
    exec(4'h0, 3'd7, 8'h20, 8'h80, 8'h11, 8'h00);
    exec(4'h0, 3'd0, 8'h21, 8'hfe, 8'h11, 8'h00);
    exec(4'h1, 3'd3, 8'h22, 8'hf7, 8'h00, 8'h00);
    exec(4'h1, 3'd3, 8'h23, 8'h08, 8'h00, 8'h00);
    exec(4'h2, 3'd0, 8'hbf, 8'h00, 8'h33, 8'h00);
    exec(4'h2, 3'd0, 8'h24, 8'h01, 8'h33, 8'h00);
    exec(4'h3, 3'd0, 8'h25, 8'h00, 8'h55, 8'h00);
    exec(4'h3, 3'd0, 8'h26, 8'h9c, 8'h55, 8'h00);
    exec(4'h4, 3'd0, 8'h27, 8'hff, 8'h12, 8'h00);
    exec(4'h4, 3'd0, 8'h28, 8'h7f, 8'h12, 8'h00);
    exec(4'h5, 3'd0, 8'h29, 8'h01, 8'h80, 8'h00);
    exec(4'h5, 3'd0, 8'h2a, 8'h05, 8'h05, 8'h00);
    exec(4'h5, 3'd0, 8'h2b, 8'h01, 8'h10, 8'h00);
    exec(4'h6, 3'd0, 8'h2c, 8'h20, 8'h10, 8'h00);
    exec(4'h7, 3'd0, 8'h2d, 8'h44, 8'h7f, 8'hff);
    exec(4'h8, 3'd0, 8'h2e, 8'h12, 8'h66, 8'h00);
    exec(4'h9, 3'd0, 8'h2f, 8'h4b, 8'h00, 8'h00);
    exec(4'ha, 3'd0, 8'h30, 8'h77, 8'h00, 8'h9a);
    exec(4'hb, 3'd0, 8'h31, 8'h77, 8'h00, 8'h3c);
    exec(4'hc, 3'd0, 8'h32, 8'ha5, 8'ha5, 8'h00);
    exec(4'hc, 3'd0, 8'h33, 8'h0f, 8'h3c, 8'h00);
    exec(4'hd, 3'd0, 8'h34, 8'h0f, 8'hf0, 8'h00);
    exec(4'he, 3'd0, 8'h35, 8'h99, 8'h3c, 8'h3c);
    exec(4'hf, 3'd0, 8'h36, 8'h5a, 8'h3c, 8'h00);
    rd(`A_CMD, 32'hffffffff, last_cmd);
    wr(8'h24, 32'hffffffff);
    rd(8'h24, 32'hffffffff, 32'h0);
    $display("test map done");
    print_verdict;
  end
endmodule
